// ### logic/wwd_pkg.sv
// constants of the windowed watchdog
`default_nettype none
package wwd_pkg;
  // register byte offsets on the bus
  localparam logic [4:0] ADR_CTRL  = 5'h00;
  localparam logic [4:0] ADR_CODE  = 5'h04;
  localparam logic [4:0] ADR_COUNT = 5'h08;
  localparam logic [4:0] ADR_STAT  = 5'h0c;
  localparam logic [4:0] ADR_ISTAT = 5'h10;
  localparam logic [4:0] ADR_IMASK = 5'h14;

  // control register fields
  localparam int CTRL_EN      = 0;
  localparam int CTRL_ACT     = 1;
  localparam int CTRL_WIN_LO  = 2;
  localparam int CTRL_PER_LO  = 4;
  localparam logic [5:0] CTRL_RESET = 6'h03;

  // control codes
  localparam logic [7:0] CODE_CLEAR   = 8'h4e;
  localparam logic [7:0] CODE_DISABLE = 8'hb1;

  // status register fields and the fixed pattern of its upper bits
  localparam int STAT_RUN = 0;
  localparam int STAT_WIN = 1;
  localparam int STAT_OVF = 2;
  localparam logic [4:0] STAT_HI = 5'h0b;

  // interrupt status and mask fields
  localparam int IRQ_OVF = 0;
  localparam int IRQ_WIN = 1;
  localparam int IRQ_RST = 2;
  localparam int IRQ_W   = 3;

  // window encodings
  localparam logic [1:0] WIN_ANY = 2'h0;

  // source clock: base divider from the 200 MHz system clock
  localparam int CLK_MHZ  = 200;
  localparam int SRC_KHZ  = 1000;
  localparam int SRC_DIV  = CLK_MHZ * 1000 / SRC_KHZ;
  localparam int PER_SHIFT = 2;

  typedef enum logic [1:0] {
    WWD_IDLE = 2'b00,
    WWD_ACK  = 2'b01
  } wwd_bus_t;
endpackage : wwd_pkg
`default_nettype wire

// ### logic/wwd_prescaler.sv
// source clock divider for the watchdog counter
`default_nettype none
module wwd_prescaler #(
  parameter int BASE_DIV = wwd_pkg::SRC_DIV,
  parameter int W        = 24
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic       hold_i,
  input  wire logic       restart_i,
  input  wire logic [1:0] period_i,
  output logic            tick_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] limit;

  // each step of the period selector stretches the tick by four
  assign limit = W'(BASE_DIV << (wwd_pkg::PER_SHIFT * int'(period_i))) - W'(1);

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || restart_i) begin
      cnt_q <= '0;
    end else if (!hold_i) begin
      cnt_q <= (cnt_q >= limit) ? '0 : cnt_q + W'(1);
    end
  end

  assign tick_o = run_i && !hold_i && !restart_i && (cnt_q >= limit);
endmodule // wwd_prescaler
`default_nettype wire

// ### logic/wwd_top.sv
// windowed watchdog with wishbone register access
// Summary of operation
// - overflow with action select 1 raises a watchdog reset request
// - the reset request resets the whole device like a normal reset
// - clear code 0x4e zeroes the counter, which keeps counting
// - disable code 0xb1 stops the watchdog only when enable bit is 0
// - clear in the same cycle as overflow wins; no overflow detected
// - count register reads the present counter value
// - running flag is 1 while enabled, 0 once disabled
// - overflow interrupt request sets the overflow cause flag
// - clear outside the window sets the window violation flag
// - reading the status register clears both cause flags
// - a flag set in the same cycle as the read stays set
// - disabling the watchdog forces the counter to zero
// - out-of-window clear raises a request, counter keeps running
// - action select 0: overflow raises a non-maskable request, counting on
// - counter holds during stop, idle and sleep, then resumes
//
// The address map and register access over Wishbone were left to the implementer.
`default_nettype none
module wwd_top #(
  parameter int BASE_DIV = wwd_pkg::SRC_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        low_power_i,
  output logic             wdt_reset_req_o,
  output logic             nmi_req_o,
  output logic             irq_o
);
  localparam int IRQ_W = wwd_pkg::IRQ_W;

  logic [5:0]         ctrl_q;
  logic               run_q;
  logic [7:0]         cnt_q;
  logic [2:1]         flag_q;
  logic [IRQ_W-1:0]   ist_q;
  logic [IRQ_W-1:0]   imask_q;
  logic [31:0]        dat_q;
  wwd_pkg::wwd_bus_t  bus_q;
  logic               rst_req_q;
  logic               nmi_q;

  // a window of 00 admits any clear; others admit only the last part
  function automatic logic in_window(input logic [1:0] sel, input logic [7:0] c);
    case (sel)
      2'h0:    in_window = 1'b1;
      2'h1:    in_window = c[7];
      2'h2:    in_window = &c[7:6];
      2'h3:    in_window = &c[7:5];
      default: in_window = 1'b1;
    endcase
  endfunction

  // bus decode
  logic       req;
  logic       acc;
  logic       wr_lo;
  logic       wr_code;
  logic       rd_stat;
  logic [7:0] wbyte;

  assign req     = wb_cyc_i && wb_stb_i;
  assign acc     = req && (bus_q == wwd_pkg::WWD_ACK);
  assign wr_lo   = acc && wb_we_i && wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];
  assign wr_code = wr_lo && (wb_adr_i == wwd_pkg::ADR_CODE);
  assign rd_stat = acc && !wb_we_i && (wb_adr_i == wwd_pkg::ADR_STAT);

  // watchdog events
  logic tick;
  logic hold;
  logic clr_cmd;
  logic clr_ok;
  logic clr_bad;
  logic dis_cmd;
  logic ovf;
  logic ovf_nmi;
  logic ovf_rst;

  assign hold    = low_power_i;
  assign clr_cmd = wr_code && (wbyte == wwd_pkg::CODE_CLEAR);
  assign dis_cmd = wr_code && (wbyte == wwd_pkg::CODE_DISABLE)
                   && !ctrl_q[wwd_pkg::CTRL_EN];
  assign clr_ok  = clr_cmd && run_q
                   && in_window(ctrl_q[wwd_pkg::CTRL_WIN_LO +: 2], cnt_q);
  assign clr_bad = clr_cmd && run_q && !clr_ok;
  // a clear or a disable in the same cycle hides the overflow
  assign ovf     = run_q && tick && (cnt_q == 8'hff) && !clr_ok && !dis_cmd;
  assign ovf_rst = ovf && ctrl_q[wwd_pkg::CTRL_ACT];
  assign ovf_nmi = ovf && !ctrl_q[wwd_pkg::CTRL_ACT];

  wwd_prescaler #(
    .BASE_DIV (BASE_DIV),
    .W        (24)
  ) u_pre (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (run_q),
    .hold_i    (hold),
    .restart_i (clr_ok),
    .period_i  (ctrl_q[wwd_pkg::CTRL_PER_LO +: 2]),
    .tick_o    (tick)
  );

  // wishbone: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= wwd_pkg::WWD_IDLE;
    end else if (bus_q == wwd_pkg::WWD_ACK) begin
      bus_q <= wwd_pkg::WWD_IDLE;
    end else if (req) begin
      bus_q <= wwd_pkg::WWD_ACK;
    end
  end

  assign wb_ack_o = acc;

  // read data captured one edge before ack; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0;
    end else if (req && bus_q == wwd_pkg::WWD_IDLE && !wb_we_i) begin
      case (wb_adr_i)
        wwd_pkg::ADR_CTRL:  dat_q <= {26'h0, ctrl_q};
        wwd_pkg::ADR_COUNT: dat_q <= {24'h0, cnt_q};
        wwd_pkg::ADR_STAT:  dat_q <= {24'h0, wwd_pkg::STAT_HI, flag_q, run_q};
        wwd_pkg::ADR_ISTAT: dat_q <= {29'h0, ist_q};
        wwd_pkg::ADR_IMASK: dat_q <= {29'h0, imask_q};
        default:            dat_q <= 32'h0;
      endcase
    end
  end

  assign wb_dat_o = dat_q;

  // control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= wwd_pkg::CTRL_RESET;
    end else if (wr_lo && wb_adr_i == wwd_pkg::ADR_CTRL) begin
      ctrl_q <= wbyte[5:0];
    end
  end

  // running state: enable bit starts it, only the disable code stops it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b1;
    end else if (dis_cmd) begin
      run_q <= 1'b0;
    end else if (wr_lo && wb_adr_i == wwd_pkg::ADR_CTRL && wbyte[wwd_pkg::CTRL_EN]) begin
      run_q <= 1'b1;
    end
  end

  // 8-bit up counter, wraps on overflow and keeps counting
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_q || dis_cmd) begin
      cnt_q <= 8'h00;
    end else if (clr_ok) begin
      cnt_q <= 8'h00;
    end else if (tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // cause flags: set beats the clear by read; only bits shown are cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 2'b00;
    end else begin
      flag_q[wwd_pkg::STAT_OVF] <= ovf_nmi
        || (flag_q[wwd_pkg::STAT_OVF] && !(rd_stat && dat_q[wwd_pkg::STAT_OVF]));
      flag_q[wwd_pkg::STAT_WIN] <= clr_bad
        || (flag_q[wwd_pkg::STAT_WIN] && !(rd_stat && dat_q[wwd_pkg::STAT_WIN]));
    end
  end

  // request outputs to the reset controller and the interrupt controller
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_req_q <= 1'b0;
      nmi_q     <= 1'b0;
    end else begin
      rst_req_q <= ovf_rst;
      nmi_q     <= ovf_nmi || clr_bad;
    end
  end

  assign wdt_reset_req_o = rst_req_q;
  assign nmi_req_o       = nmi_q;

  // sticky interrupt status, write one to clear; set wins
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;

  assign ev  = {ovf_rst, clr_bad, ovf_nmi};
  assign w1c = (wr_lo && wb_adr_i == wwd_pkg::ADR_ISTAT) ? wbyte[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~w1c) | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imask_q <= '0;
    end else if (wr_lo && wb_adr_i == wwd_pkg::ADR_IMASK) begin
      imask_q <= wbyte[IRQ_W-1:0];
    end
  end

  // the nmi path ignores this mask; irq_o is the maskable summary
  assign irq_o = |(ist_q & imask_q);

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_CLEAR_ZERO: assert property (clr_ok |=> cnt_q == 8'h00)
    else $error("clear code did not zero the counter");

  AST_DISABLE_ONLY_WHEN_EN0: assert property (
    wr_code && wbyte == wwd_pkg::CODE_DISABLE && ctrl_q[wwd_pkg::CTRL_EN] && run_q
    |=> run_q)
    else $error("disable code acted while enable bit was set");

  AST_DISABLE_ZEROES: assert property (!run_q |-> ##1 (cnt_q == 8'h00 && !run_q) or ##1 run_q)
    else $error("counter not zero while disabled");

  AST_CLEAR_BEATS_OVF: assert property (clr_ok |=> !nmi_req_o && !wdt_reset_req_o)
    else $error("overflow reported together with a clear");

  AST_RESET_REQ: assert property (
    run_q && tick && cnt_q == 8'hff && !clr_cmd && !wr_code && ctrl_q[wwd_pkg::CTRL_ACT]
    |=> wdt_reset_req_o ##1 !wdt_reset_req_o)
    else $error("overflow did not give a one-cycle reset request");

  AST_NMI_KEEPS_COUNTING: assert property (ovf_nmi |=> nmi_req_o && cnt_q == 8'h00 && run_q)
    else $error("nmi overflow stopped the counter");

  AST_OVF_FLAG: assert property (ovf_nmi |=> flag_q[wwd_pkg::STAT_OVF])
    else $error("overflow flag not set");

  AST_WIN_FLAG: assert property (clr_bad |=> flag_q[wwd_pkg::STAT_WIN] &&
    (cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) + 8'h01))
    else $error("window violation not flagged or counter cleared");

  AST_READ_CLEARS: assert property (
    rd_stat && !ovf_nmi && !clr_bad |=> (flag_q & dat_q[2:1]) == 2'b00)
    else $error("status read did not clear the shown flags");

  AST_SET_WINS: assert property (rd_stat && ovf_nmi |=> flag_q[wwd_pkg::STAT_OVF])
    else $error("flag lost when set during status read");

  AST_HOLD: assert property (hold && run_q && !wr_code |=> $stable(cnt_q))
    else $error("counter moved in a low power mode");

  AST_RUN_FLAG: assert property (dis_cmd |=> !run_q ##1 (cnt_q == 8'h00))
    else $error("running flag still set after disable");

  AST_COUNT_READ: assert property (
    req && bus_q == wwd_pkg::WWD_IDLE && !wb_we_i && wb_adr_i == wwd_pkg::ADR_COUNT
    |=> wb_ack_o && wb_dat_o[7:0] == $past(cnt_q))
    else $error("count read returned a stale value");

  // handshake, request outputs, clear acceptance, running state and tick gating
  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack stood for more than one cycle");

  AST_RST_REQ_PULSE: assert property (
    wdt_reset_req_o |=> !wdt_reset_req_o)
    else $error("reset request longer than one cycle");

  AST_DISABLE_HIDES_OVF: assert property (
    dis_cmd |=> !nmi_req_o && !wdt_reset_req_o)
    else $error("overflow reported together with a disable");

  AST_OUT_OF_WINDOW_NMI: assert property (
    clr_bad |=> nmi_req_o)
    else $error("out of window clear gave no request");

  AST_WINDOW_ANY: assert property (
    clr_cmd && run_q && ctrl_q[wwd_pkg::CTRL_WIN_LO +: 2] == wwd_pkg::WIN_ANY |-> clr_ok)
    else $error("clear refused with the window open at all times");

  AST_RUN_STARTS: assert property (
    wr_lo && wb_adr_i == wwd_pkg::ADR_CTRL && wbyte[wwd_pkg::CTRL_EN] |=> run_q)
    else $error("running flag not set by the enable bit");

  AST_NO_TICK_WHEN_OFF: assert property (
    !run_q |-> !tick)
    else $error("source tick while the watchdog is off");

  AST_IDLE_CLEAR_IGNORED: assert property (
    clr_cmd && !run_q |=> !nmi_req_o && cnt_q == 8'h00)
    else $error("clear code acted while the watchdog is off");

  // counting and sticky status
  AST_TICK_STEP: assert property (
    tick && !wr_code |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not step by one on a tick");

  AST_NO_TICK_HOLDS: assert property (
    run_q && !tick && !wr_code |=> $stable(cnt_q))
    else $error("counter moved without a tick");

  AST_NMI_STATUS: assert property (
    ovf_nmi |=> ist_q[wwd_pkg::IRQ_OVF])
    else $error("nmi overflow not held in the interrupt status");

  AST_RST_STATUS: assert property (
    ovf_rst |=> ist_q[wwd_pkg::IRQ_RST])
    else $error("reset overflow not held in the interrupt status");

  AST_WIN_STATUS: assert property (
    clr_bad |=> ist_q[wwd_pkg::IRQ_WIN])
    else $error("window violation not held in the interrupt status");

  AST_FLAG_KEPT: assert property (
    flag_q[wwd_pkg::STAT_WIN] && !rd_stat |=> flag_q[wwd_pkg::STAT_WIN])
    else $error("window flag lost without a status read");

  COV_OVERFLOW_NMI: cover property (ovf_nmi);
  COV_OVERFLOW_RESET: cover property (ovf_rst);
  COV_WINDOW_VIOLATION: cover property (clr_bad);
  COV_READ_AND_SET: cover property (rd_stat && (ovf_nmi || clr_bad));
  COV_CLEAR_IN_WINDOW: cover property (clr_ok && ctrl_q[wwd_pkg::CTRL_WIN_LO +: 2] != wwd_pkg::WIN_ANY);
endmodule // wwd_top
`default_nettype wire

// ### verification/windowed_watchdog_timer_bench.sv
// self-checking bench for the windowed watchdog
`default_nettype none
module windowed_watchdog_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i, rst_i, cyc, stb, we, low_power;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rd_dat, c1, c2;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, wdt_reset_req_o, nmi_req_o, irq_o;
  logic [31:0] seed = 32'h7303;
  int          err_count = 0, cmp_count = 0, nmi_cnt = 0, rst_cnt = 0, cyc_cnt = 0;

  // short source tick keeps one overflow at 512 cycles
  wwd_top #(.BASE_DIV(2)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .low_power_i(low_power), .wdt_reset_req_o(wdt_reset_req_o),
    .nmi_req_o(nmi_req_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] stat_exp(input logic run, input logic win, input logic ovf);
    return {24'h0, wwd_pkg::STAT_HI, ovf, win, run};
  endfunction

  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // pulses are one cycle wide, so tally them as they pass
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (nmi_req_o === 1'b1) nmi_cnt++;
    if (wdt_reset_req_o === 1'b1) rst_cnt++;
    if (cyc_cnt > 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd_dat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_pulse(input bit rst_kind, input int lim);
    int base;
    base = rst_kind ? rst_cnt : nmi_cnt;
    for (int i = 0; i < lim && (rst_kind ? rst_cnt : nmi_cnt) == base; i++) @(posedge clk_i);
    chk(32'((rst_kind ? rst_cnt : nmi_cnt) != base), 32'h1);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 5'h00;
    sel = 4'hf; wdat = 32'h0; low_power = 1'b0;
    do_reset();
    bus(1'b0, wwd_pkg::ADR_CTRL, 32'h0); chk(rd_dat, 32'h03);
    bus(1'b0, wwd_pkg::ADR_STAT, 32'h0); chk(rd_dat, stat_exp(1'b1, 1'b0, 1'b0));
    bus(1'b0, 5'h1c, 32'h0); chk(rd_dat, 32'h0);
    for (int i = 0; i < 4; i++) begin
      c1 = xs() & 32'h7;
      bus(1'b1, wwd_pkg::ADR_IMASK, c1);
      bus(1'b0, wwd_pkg::ADR_IMASK, 32'h0); chk(rd_dat, c1);
    end
    bus(1'b1, wwd_pkg::ADR_IMASK, 32'h0);
    // counter frozen in low power, then moving again; both reads lie inside the hold
    low_power <= 1'b1;
    repeat (2) @(posedge clk_i);
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); c1 = rd_dat;
    repeat (40) @(posedge clk_i);
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); c2 = rd_dat;
    low_power <= 1'b0;
    chk(c2, c1);
    repeat (20 + (xs() & 32'h1f)) @(posedge clk_i);
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); chk(32'(rd_dat > c2), 32'h1);
    bus(1'b1, wwd_pkg::ADR_CODE, {24'h0, wwd_pkg::CODE_CLEAR});
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); chk(32'(rd_dat <= 2), 32'h1);
    repeat (30) @(posedge clk_i);
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); chk(32'(rd_dat > 2), 32'h1);
    // overflow with reset action
    wait_pulse(1'b1, 700);
    bus(1'b0, wwd_pkg::ADR_ISTAT, 32'h0); chk(rd_dat & 32'h4, 32'h4);
    bus(1'b1, wwd_pkg::ADR_ISTAT, 32'h4);
    bus(1'b0, wwd_pkg::ADR_ISTAT, 32'h0); chk(rd_dat, 32'h0);
    bus(1'b1, wwd_pkg::ADR_CTRL, 32'h3c);
    do_reset();
    bus(1'b0, wwd_pkg::ADR_CTRL, 32'h0); chk(rd_dat, 32'h03);
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); chk(32'(rd_dat <= 2), 32'h1);
    // overflow with interrupt action
    bus(1'b1, wwd_pkg::ADR_CTRL, 32'h01);
    wait_pulse(1'b0, 700);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    bus(1'b1, wwd_pkg::ADR_IMASK, 32'h1);
    @(posedge clk_i);
    chk(32'(irq_o), 32'h1);
    bus(1'b0, wwd_pkg::ADR_STAT, 32'h0); chk(rd_dat, stat_exp(1'b1, 1'b0, 1'b1));
    bus(1'b0, wwd_pkg::ADR_STAT, 32'h0); chk(rd_dat, stat_exp(1'b1, 1'b0, 1'b0));
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); chk(32'(rd_dat > 0), 32'h1);
    bus(1'b1, wwd_pkg::ADR_ISTAT, 32'h1);
    @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    // window 01: clear too early, then inside the window
    bus(1'b1, wwd_pkg::ADR_CODE, {24'h0, wwd_pkg::CODE_CLEAR});
    bus(1'b1, wwd_pkg::ADR_CTRL, 32'h05);
    repeat (20) @(posedge clk_i);
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); c1 = rd_dat;
    bus(1'b1, wwd_pkg::ADR_CODE, {24'h0, wwd_pkg::CODE_CLEAR});
    wait_pulse(1'b0, 8);
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); chk(32'(rd_dat >= c1), 32'h1);
    bus(1'b0, wwd_pkg::ADR_STAT, 32'h0); chk(rd_dat, stat_exp(1'b1, 1'b1, 1'b0));
    for (int i = 0; i < 200 && rd_dat < 32'h80; i++) bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0);
    c2 = nmi_cnt;
    bus(1'b1, wwd_pkg::ADR_CODE, {24'h0, wwd_pkg::CODE_CLEAR});
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); chk(32'(rd_dat <= 2), 32'h1);
    chk(32'(nmi_cnt) - c2, 32'h0);
    // disable code only works with the enable bit low
    bus(1'b1, wwd_pkg::ADR_CODE, {24'h0, wwd_pkg::CODE_DISABLE});
    bus(1'b0, wwd_pkg::ADR_STAT, 32'h0); chk(rd_dat, stat_exp(1'b1, 1'b0, 1'b0));
    bus(1'b1, wwd_pkg::ADR_CTRL, 32'h04);
    bus(1'b1, wwd_pkg::ADR_CODE, {24'h0, wwd_pkg::CODE_DISABLE});
    bus(1'b0, wwd_pkg::ADR_STAT, 32'h0); chk(rd_dat, stat_exp(1'b0, 1'b0, 1'b0));
    // a clear while stopped must neither start counting nor flag a violation
    c2 = nmi_cnt;
    bus(1'b1, wwd_pkg::ADR_CODE, {24'h0, wwd_pkg::CODE_CLEAR});
    repeat (50) @(posedge clk_i);
    bus(1'b0, wwd_pkg::ADR_COUNT, 32'h0); chk(rd_dat, 32'h0);
    chk(32'(nmi_cnt) - c2, 32'h0);
    report_and_stop();
  end
endmodule // windowed_watchdog_timer_bench
`default_nettype wire
